// ==== pkg/dpp_pkg.sv ====
/*
  Shared constants, mode encoding and state layout of the dual parallel port.
  Assumes one 25 MHz clock and a synchronous, active-low reset.
*/
package dpp_pkg;

  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int DPP_PORTS = 2;
  localparam int DPP_DATA_W = 8;
  localparam int DPP_FIFO_DEPTH = 32;
  localparam int DPP_CLK_MHZ = 25;
  localparam logic [1:0] M1_RESET_CYCLES = 2'h2;

  // ----------------------------------------
  // Modes and control words
  // ----------------------------------------
  typedef enum logic [1:0] {
    DPP_MODE_OUT = 2'h0,
    DPP_MODE_IN = 2'h1,
    DPP_MODE_BIDIR = 2'h2,
    DPP_MODE_BIT = 2'h3
  } dpp_mode_t;

  localparam logic [3:0] CW_MODE_CODE = 4'hf;
  localparam logic [3:0] CW_IRQ_CODE = 4'h7;
  localparam logic [3:0] CW_IEN_CODE = 4'h3;
  localparam int CW_VEC_BIT = 0;
  localparam int CW_MASK_BIT = 4;
  localparam int CW_HIGH_BIT = 5;
  localparam int CW_AND_BIT = 6;
  localparam int CW_IEN_BIT = 7;
  localparam logic [7:0] RETURN_FROM_IRQ_OPCODE_PREFIX = 8'hed;
  localparam logic [7:0] RETURN_FROM_IRQ_OPCODE_CODE = 8'h4d;
  localparam logic [7:0] CTRL_READ_VALUE = 8'h00;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [7:0] OUT_RESET = 8'h00;

  typedef struct packed {
    dpp_mode_t [1:0] mode;
    logic [1:0] cfg, ie, exp_dir, exp_mask, in_full, out_rdy;
    logic [1:0] pend, serv, stb_q, match_q;
    logic [1:0][1:0] cond;
    logic [1:0][7:0] mask, dir, vec, outd, ind;
    logic acc_q, fetch_q, iack_q, ack_q, ed_seen, m1_q;
    logic [1:0] m1_cnt;
    logic [7:0] dout;
  } dpp_state_t;

  function automatic dpp_state_t dpp_reset_state();
    dpp_state_t s;
    s = '0;
    s.mode[0] = DPP_MODE_IN;
    s.mode[1] = DPP_MODE_IN;
    s.mask = {DPP_PORTS{MASK_RESET}};
    s.dir = {DPP_PORTS{DIR_RESET}};
    s.outd = {DPP_PORTS{OUT_RESET}};
    s.stb_q = 2'h3;
    s.m1_q = 1'b1;
    return s;
  endfunction

endpackage

// ==== hdl/dpp_top.sv ====
/*
  Dual 8-bit parallel port with handshake, bit mode and daisy-chained
  vectored interrupts, plus the input FIFO it uses.
  Assumes all host bus and peripheral inputs are synchronous to clock_in.
*/
// What this block does
// - Two independent 8-bit ports, each with strobe input and ready output.
// - Modes output, input, bidirectional (port A only) and bit control.
// - Control/data select low means port data, high means control word.
// - Port select low addresses port A, high addresses port B.
// - Reads and writes answered only while chip select is low.
// - Opcode fetch and I/O request both low is interrupt acknowledge.
// - Host drops I/O request for accesses; read strobe sets direction.
// - Strobe meaning follows mode; port B strobe serves port A bidirectional.
// - Ready per port; port B ready serves port A bidirectional input.
// - A stopped clock freezes all state, giving standby.
// - Interrupt request is an active-low open-drain output.
// - Host-loaded 8-bit output register per port drives the pins.
// - Peripheral data latched in 8-bit input register, returned on reads.
// - Two-bit mode register per port set by control words.
// - Eight-bit vector per port supplied during acknowledge.
// - Two-bit monitor condition per port, used only in bit mode.
// - Eight-bit pin mask per port, used only in bit mode.
// - Eight-bit direction per port, used only in bit mode.
// - Fetch strobe low two clocks, others high, resets on its rise.
// - Reset: input mode, no interrupts, data cleared, masks set, lines float.
// - No interrupt request while chain enable is low.
// - Watch the data bus for the return opcode to end servicing.
`timescale 1ns/1ps

// ----------------------------------------
// Input FIFO
// ----------------------------------------
module dpp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp, rp;
    logic [AW:0] cnt;
  } dpp_fifo_t;

  dpp_fifo_t s_r, s_nxt;
  logic push, pop;

  assign in_ready_out = s_r.cnt != (AW+1)'(DEPTH);
  assign out_valid_out = s_r.cnt != '0;
  assign out_data_out = s_r.mem[s_r.rp];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data_in;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (clear_in) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ----------------------------------------
// Port controller
// ----------------------------------------
module dpp_top import dpp_pkg::*; (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  input wire logic chip_select_n_in,
  input wire logic ctrl_data_sel_in,
  input wire logic port_sel_in,
  input wire logic io_request_n_in,
  input wire logic read_n_in,
  input wire logic opcode_fetch_n_in,
  input wire logic chain_enable_in,
  output logic chain_enable_out,
  output logic irq_n_out,
  output logic irq_n_oe_out,
  input wire logic [7:0] port_a_data_in,
  output logic [7:0] port_a_data_out,
  output logic [7:0] port_a_oe_out,
  input wire logic [7:0] port_b_data_in,
  output logic [7:0] port_b_data_out,
  output logic [7:0] port_b_oe_out,
  input wire logic port_a_strobe_n_in,
  input wire logic port_b_strobe_n_in,
  output logic port_a_ready_out,
  output logic port_b_ready_out
);
  dpp_state_t st_r, st_nxt;
  logic [1:0] ev;
  logic acc, wr, rd, acc_start, fetch, fetch_start, iack, iack_start;
  logic m1_only, soft_rst, ack_go, asel, bidir, ps;
  wire [1:0][7:0] pin_in = {port_b_data_in, port_a_data_in};
  wire [1:0] stb_n = {port_b_strobe_n_in, port_a_strobe_n_in};
  wire [1:0][7:0] pin_oe, fdata, mset, lvl;
  wire [1:0] outm, inm, bitm, istb, istb_q, in_fall, in_rise;
  wire [1:0] o_fall, o_rise, hit, bit_ev, push_rdy, fvalid, rdy;

  // ----------------------------------------
  // Host bus decode
  // ----------------------------------------
  assign bidir = st_r.mode[0] == DPP_MODE_BIDIR;
  assign ps = port_sel_in;
  // only a selected I/O cycle outside fetch is an access
  assign acc = !chip_select_n_in && !io_request_n_in && opcode_fetch_n_in;
  // write strobe needs read and fetch strobes high
  assign wr = acc && read_n_in;
  assign rd = acc && !read_n_in;
  assign acc_start = acc && !st_r.acc_q;
  assign fetch = !opcode_fetch_n_in && !read_n_in && io_request_n_in;
  assign fetch_start = fetch && !st_r.fetch_q;
  // fetch and I/O request together mark an acknowledge
  assign iack = !opcode_fetch_n_in && !io_request_n_in;
  assign iack_start = iack && !st_r.iack_q;
  assign m1_only = !opcode_fetch_n_in && read_n_in && io_request_n_in;
  // long fetch pulse with no other strobe resets on its rising edge
  assign soft_rst = opcode_fetch_n_in && !st_r.m1_q && st_r.m1_cnt >= M1_RESET_CYCLES;
  assign ack_go = iack_start && chain_enable_in && |st_r.pend;
  // Port A ranks above port B in the chain
  assign asel = !st_r.pend[0];

  // ----------------------------------------
  // Per-port handshake and monitoring
  // ----------------------------------------
  for (genvar g = 0; g < DPP_PORTS; g++) begin : g_port
    // port B never takes the bidirectional role
    assign outm[g] = st_r.cfg[g] && (st_r.mode[g] == DPP_MODE_OUT || (g == 0 && bidir));
    assign inm[g] = st_r.cfg[g] && !(g == 1 && bidir)
      && (st_r.mode[g] == DPP_MODE_IN || (g == 0 && bidir));
    assign bitm[g] = st_r.cfg[g] && st_r.mode[g] == DPP_MODE_BIT;
    // in bidirectional mode the input strobe of port A is port B's
    assign istb[g] = (g == 0 && bidir) ? stb_n[1] : stb_n[g];
    assign istb_q[g] = (g == 0 && bidir) ? st_r.stb_q[1] : st_r.stb_q[g];
    assign in_fall[g] = inm[g] && istb_q[g] && !istb[g];
    assign in_rise[g] = inm[g] && !istb_q[g] && istb[g];
    assign o_fall[g] = outm[g] && st_r.stb_q[g] && !stb_n[g];
    assign o_rise[g] = outm[g] && !st_r.stb_q[g] && stb_n[g];
    // unmasked input pins at the chosen level, all or any
    assign mset[g] = st_r.dir[g] & ~st_r.mask[g];
    assign lvl[g] = st_r.cond[g][0] ? pin_in[g] : ~pin_in[g];
    assign hit[g] = st_r.cond[g][1]
      ? (mset[g] != 8'h00 && (lvl[g] | ~mset[g]) == 8'hff)
      : |(lvl[g] & mset[g]);
    assign bit_ev[g] = bitm[g] && !(g == 1 && bidir) && hit[g] && !st_r.match_q[g];
    // direction only counts in bit mode; lines float until set up
    assign pin_oe[g] = (st_r.cfg[g] && st_r.mode[g] == DPP_MODE_OUT) ? 8'hff
      : (g == 0 && st_r.cfg[0] && bidir && !stb_n[0]) ? 8'hff
      : bitm[g] ? ~st_r.dir[g] : 8'h00;

    // Ready drops when the FIFO fills, so the peripheral is held off
    dpp_fifo #(
      .WIDTH(DPP_DATA_W),
      .DEPTH(DPP_FIFO_DEPTH)
    ) u_fifo (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .clear_in(soft_rst),
      .in_valid_in(in_fall[g]),
      .in_ready_out(push_rdy[g]),
      .in_data_in(pin_in[g]),
      .out_valid_out(fvalid[g]),
      .out_ready_in(!st_r.in_full[g]),
      .out_data_out(fdata[g])
    );
  end

  // port B ready carries port A input handshake in bidirectional mode
  assign rdy[0] = outm[0] ? st_r.out_rdy[0] : inm[0] ? push_rdy[0] : 1'b0;
  assign rdy[1] = bidir ? (st_r.cfg[0] && push_rdy[0])
    : outm[1] ? st_r.out_rdy[1] : inm[1] ? push_rdy[1] : 1'b0;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    ev = 2'h0;
    st_nxt.stb_q = stb_n;
    st_nxt.m1_q = opcode_fetch_n_in;
    st_nxt.acc_q = acc;
    st_nxt.fetch_q = fetch;
    st_nxt.iack_q = iack;
    st_nxt.ack_q = iack && (st_r.ack_q || ack_go);
    st_nxt.m1_cnt = !m1_only ? 2'h0
      : (st_r.m1_cnt < M1_RESET_CYCLES) ? st_r.m1_cnt + 2'h1 : st_r.m1_cnt;
    st_nxt.match_q = hit;
    for (int p = 0; p < DPP_PORTS; p++) begin
      if (bitm[p]) begin
        st_nxt.ind[p] = (pin_in[p] & st_r.dir[p]) | (st_r.outd[p] & ~st_r.dir[p]);
      end
      // FIFO head moves into the input register once it is free
      if (fvalid[p] && !st_r.in_full[p]) begin
        st_nxt.ind[p] = fdata[p];
        st_nxt.in_full[p] = 1'b1;
      end
      if (o_fall[p]) begin
        st_nxt.out_rdy[p] = 1'b0;
      end
      ev[p] = ev[p] | o_rise[p] | bit_ev[p];
      // Input interrupt in bidirectional mode uses port B's vector
      if (in_rise[p]) begin
        ev[(p == 0 && bidir) ? 1 : p] = 1'b1;
      end
    end
    // select lines pick data or control and the port
    if (wr && acc_start) begin
      if (!ctrl_data_sel_in) begin
        // host data lands in the output register
        st_nxt.outd[ps] = data_in;
        st_nxt.out_rdy[ps] = outm[ps];
      end else if (st_r.exp_dir[ps]) begin
        st_nxt.dir[ps] = data_in;
        st_nxt.exp_dir[ps] = 1'b0;
      end else if (st_r.exp_mask[ps]) begin
        st_nxt.mask[ps] = data_in;
        st_nxt.exp_mask[ps] = 1'b0;
      end else if (!data_in[CW_VEC_BIT]) begin
        st_nxt.vec[ps] = data_in;
      end else if (data_in[3:0] == CW_MODE_CODE) begin
        // bidirectional request on port B is ignored
        if (!(ps && dpp_mode_t'(data_in[7:6]) == DPP_MODE_BIDIR)) begin
          st_nxt.mode[ps] = dpp_mode_t'(data_in[7:6]);
          st_nxt.cfg[ps] = 1'b1;
          st_nxt.out_rdy[ps] = 1'b0;
          st_nxt.exp_dir[ps] = dpp_mode_t'(data_in[7:6]) == DPP_MODE_BIT;
        end
      end else if (data_in[3:0] == CW_IRQ_CODE) begin
        st_nxt.ie[ps] = data_in[CW_IEN_BIT];
        st_nxt.cond[ps] = {data_in[CW_AND_BIT], data_in[CW_HIGH_BIT]};
        st_nxt.exp_mask[ps] = data_in[CW_MASK_BIT];
      end else if (data_in[3:0] == CW_IEN_CODE) begin
        st_nxt.ie[ps] = data_in[CW_IEN_BIT];
      end
    end
    if (rd && acc_start) begin
      st_nxt.dout = ctrl_data_sel_in ? CTRL_READ_VALUE : st_r.ind[ps];
      if (!ctrl_data_sel_in && inm[ps] && st_r.in_full[ps]) begin
        st_nxt.in_full[ps] = 1'b0;
      end
    end
    if (ack_go) begin
      st_nxt.dout = st_r.vec[asel];
      st_nxt.serv[asel] = 1'b1;
      st_nxt.pend[asel] = 1'b0;
    end
    // return opcode pair seen on fetches ends the top service level
    if (fetch_start) begin
      st_nxt.ed_seen = data_in == RETURN_FROM_IRQ_OPCODE_PREFIX;
      if (st_r.ed_seen && data_in == RETURN_FROM_IRQ_OPCODE_CODE) begin
        if (st_r.serv[0]) begin
          st_nxt.serv[0] = 1'b0;
        end else begin
          st_nxt.serv[1] = 1'b0;
        end
      end
    end
    // A new event outranks the clear from an acknowledge
    st_nxt.pend = st_nxt.pend | (ev & st_r.ie);
    // all configuration returns to its reset value
    if (soft_rst) begin
      st_nxt = dpp_reset_state();
    end
  end

  // no clock edge, no state change; the block idles on a held clock
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      st_r <= dpp_reset_state();
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign data_out = st_r.dout;
  assign data_oe_out = (rd && st_r.acc_q) || (iack && st_r.ack_q);
  // open-drain request pulled only while the chain allows it
  assign irq_n_out = 1'b0;
  assign irq_n_oe_out = chain_enable_in && |st_r.pend;
  assign chain_enable_out = chain_enable_in && !(|st_r.serv) && !(|st_r.pend);
  assign port_a_data_out = st_r.outd[0];
  assign port_b_data_out = st_r.outd[1];
  assign port_a_oe_out = pin_oe[0];
  assign port_b_oe_out = pin_oe[1];
  // each port has its own ready, except that port B ready serves port A input in bidirectional mode
  assign port_a_ready_out = rdy[0];
  assign port_b_ready_out = rdy[1];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  out_latch_a: assert property (
    (wr && acc_start && !ctrl_data_sel_in && !ps && !soft_rst)
    |=> port_a_data_out == $past(data_in)) else $error("port A output not latched");
  chain_gate_a: assert property (
    !chain_enable_in |-> !irq_n_oe_out && !chain_enable_out)
    else $error("request raised with chain low");
  m1_reset_a: assert property (
    soft_rst |=> !port_a_ready_out && !port_b_ready_out
    && port_a_oe_out == 8'h00 && port_b_oe_out == 8'h00)
    else $error("long fetch pulse did not reset");
  bus_select_a: assert property (
    (chip_select_n_in && opcode_fetch_n_in) |-> !data_oe_out)
    else $error("bus driven while unselected");
  ack_vector_a: assert property (
    (ack_go && st_r.pend[0]) |=> st_r.serv[0] && data_out == $past(st_r.vec[0]))
    else $error("wrong vector on acknowledge");
  input_float_a: assert property (
    (inm[0] && !bidir) |-> port_a_oe_out == 8'h00)
    else $error("input port drives its pins");
  return_from_irq_opcode_end_a: assert property (
    (fetch_start && st_r.ed_seen && data_in == RETURN_FROM_IRQ_OPCODE_CODE && st_r.serv[0])
    |=> !st_r.serv[0]) else $error("return opcode ignored");
  read_data_a: assert property (
    (rd && acc_start && !ctrl_data_sel_in && !ps) ##1 rd
    |-> data_oe_out && data_out == $past(st_r.ind[0]))
    else $error("read did not return input register");
endmodule

// ==== tb/dpp_periph_model.sv ====
/*
  Peripheral on one port of the dual parallel port: drives pin levels and the strobe.
  Assumes the bench calls its tasks and that the device changes outputs on clock_in rise.
*/
`timescale 1ns/1ps

module dpp_periph_model (
  input wire logic clock_in,
  input wire logic [7:0] dev_data_in,
  input wire logic [7:0] dev_oe_in,
  output logic [7:0] pin_level_out,
  output logic strobe_n_out
);
  logic [7:0] drv_r;
  logic [7:0] idle_r;
  logic hold_r;

  initial begin
    drv_r = 8'h00;
    idle_r = 8'h5a;
    hold_r = 1'b0;
    strobe_n_out = 1'b1;
  end

  // ----------------------------------------
  // Pin levels
  // ----------------------------------------
  // Released lines toggle every cycle so stale data can never pass for a match
  always @(negedge clock_in) begin
    idle_r <= ~idle_r;
  end

  assign pin_level_out = (dev_oe_in & dev_data_in) | (~dev_oe_in & (hold_r ? drv_r : idle_r));

  // ----------------------------------------
  // Handshake
  // ----------------------------------------
  // strobe low one cycle
  task automatic send(input logic [7:0] d);
    @(negedge clock_in);
    drv_r = d;
    hold_r = 1'b1;
    strobe_n_out = 1'b0;
    @(negedge clock_in);
    strobe_n_out = 1'b1;
    @(negedge clock_in);
    hold_r = 1'b0;
  endtask

  task automatic hold_pins(input logic [7:0] d, input logic on);
    @(negedge clock_in);
    drv_r = d;
    hold_r = on;
  endtask
endmodule

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for the dual parallel port: host bus tasks and one task per scenario.
  Assumes dpp_top, dpp_fifo and the peripheral model are compiled before it.
*/
`timescale 1ns/1ps

module tb_top import dpp_pkg::*;;
  logic clk, rst_n, cs_n, cds, ps, io_request_n_n, rd_n, m1_n, chain_in, bus_oe;
  logic [7:0] dbus, rdat;
  int n_errors, checked, cycles;
  wire logic [7:0] d_out, pa_out, pa_oe, pb_out, pb_oe, pa_lvl, pb_lvl;
  wire logic d_oe, chain_out, irq_n, irq_oe, pa_rdy, pb_rdy, pa_stb_n, pb_stb_n;

  dpp_top i_dut (.clock_in(clk), .rst_n_in(rst_n), .data_in(dbus), .data_out(d_out),
    .data_oe_out(d_oe), .chip_select_n_in(cs_n), .ctrl_data_sel_in(cds), .port_sel_in(ps),
    .io_request_n_in(io_request_n_n), .read_n_in(rd_n), .opcode_fetch_n_in(m1_n),
    .chain_enable_in(chain_in), .chain_enable_out(chain_out), .irq_n_out(irq_n),
    .irq_n_oe_out(irq_oe), .port_a_data_in(pa_lvl), .port_a_data_out(pa_out),
    .port_a_oe_out(pa_oe), .port_b_data_in(pb_lvl), .port_b_data_out(pb_out),
    .port_b_oe_out(pb_oe), .port_a_strobe_n_in(pa_stb_n), .port_b_strobe_n_in(pb_stb_n),
    .port_a_ready_out(pa_rdy), .port_b_ready_out(pb_rdy));
  dpp_periph_model i_pa (.clock_in(clk), .dev_data_in(pa_out), .dev_oe_in(pa_oe),
    .pin_level_out(pa_lvl), .strobe_n_out(pa_stb_n));
  dpp_periph_model i_pb (.clock_in(clk), .dev_data_in(pb_out), .dev_oe_in(pb_oe),
    .pin_level_out(pb_lvl), .strobe_n_out(pb_stb_n));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One access, then one idle cycle as the bus requires
  task automatic bus(input logic c, d, p, r, input logic [7:0] w);
    @(negedge clk);
    cs_n = c;
    cds = d;
    ps = p;
    rd_n = ~r;
    io_request_n_n = 1'b0;
    dbus = w;
    @(negedge clk);
    rdat = d_out;
    bus_oe = d_oe;
    cs_n = 1'b1;
    io_request_n_n = 1'b1;
    rd_n = 1'b1;
    @(negedge clk);
  endtask

  task automatic fetch(input logic [7:0] op);
    @(negedge clk);
    m1_n = 1'b0;
    rd_n = 1'b0;
    dbus = op;
    @(negedge clk);
    m1_n = 1'b1;
    rd_n = 1'b1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk({3'h0, d_oe, irq_oe, pa_rdy, pb_rdy, chain_out}, 8'h01);
    chk(pa_oe | pb_oe, 8'h00);
    chk(pa_out | pb_out, 8'h00);
    $display("done: reset state");
  endtask

  task automatic t_output;
    bus(1'b0, 1'b1, 1'b0, 1'b0, 8'h0f);
    bus(1'b0, 1'b0, 1'b0, 1'b0, 8'h5a);
    chk(pa_out, 8'h5a);
    chk(pa_oe, 8'hff);
    chk(pb_out, 8'h00);
    chk({7'h00, pa_rdy}, 8'h01);
    i_pa.send(8'h00);
    chk({6'h00, pa_rdy, irq_oe}, 8'h00);
    $display("done: output mode");
  endtask

  task automatic t_irq;
    bus(1'b0, 1'b1, 1'b0, 1'b0, 8'h20);
    bus(1'b0, 1'b1, 1'b0, 1'b0, 8'h87);
    bus(1'b0, 1'b0, 1'b0, 1'b0, 8'h11);
    i_pa.send(8'h00);
    chk({6'h00, irq_oe, chain_out}, 8'h02);
    chk({7'h00, irq_n}, 8'h00);
    chain_in = 1'b0;
    @(negedge clk);
    chk({6'h00, irq_oe, chain_out}, 8'h00);
    chain_in = 1'b1;
    m1_n = 1'b0;
    io_request_n_n = 1'b0;
    @(negedge clk);
    chk({7'h00, d_oe}, 8'h01);
    chk(d_out, 8'h20);
    m1_n = 1'b1;
    io_request_n_n = 1'b1;
    @(negedge clk);
    chk({6'h00, irq_oe, chain_out}, 8'h00);
    fetch(RETURN_FROM_IRQ_OPCODE_PREFIX);
    fetch(RETURN_FROM_IRQ_OPCODE_CODE);
    @(negedge clk);
    chk({7'h00, chain_out}, 8'h01);
    $display("done: interrupt cycle");
  endtask

  task automatic t_fifo;
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'h4f);
    chk(pb_oe, 8'h00);
    chk({7'h00, pb_rdy}, 8'h01);
    for (int k = 0; k <= DPP_FIFO_DEPTH; k++) begin
      i_pb.send(8'h40 + 8'(k));
    end
    chk({7'h00, pb_rdy}, 8'h00);
    bus(1'b1, 1'b0, 1'b1, 1'b1, 8'h00);
    chk({7'h00, bus_oe}, 8'h00);
    for (int k = 0; k <= DPP_FIFO_DEPTH; k++) begin
      bus(1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
      chk({7'h00, bus_oe}, 8'h01);
      chk(rdat, 8'h40 + 8'(k));
      @(negedge clk);
    end
    chk({7'h00, pb_rdy}, 8'h01);
    $display("done: input fifo");
  endtask

  task automatic t_bit;
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'hcf);
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'h0f);
    bus(1'b0, 1'b0, 1'b1, 1'b0, 8'ha5);
    i_pb.hold_pins(8'h3c, 1'b1);
    chk(pb_oe, 8'hf0);
    chk(pb_out, 8'ha5);
    bus(1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
    chk(rdat, 8'hac);
    i_pb.hold_pins(8'h00, 1'b0);
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'h8f);
    chk(pb_oe, 8'hf0);
    bus(1'b0, 1'b1, 1'b0, 1'b0, 8'h8f);
    chk(pa_oe, 8'h00);
    chk({7'h00, pb_rdy}, 8'h01);
    // Port A input in bidirectional mode is strobed by port B's line
    i_pa.hold_pins(8'h77, 1'b1);
    i_pb.send(8'h00);
    bus(1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    chk(rdat, 8'h77);
    $display("done: bit mode");
  endtask

  task automatic t_bitirq;
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'hcf);
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'h0f);
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'h40);
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'hf7);
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'hfc);
    // Pins 0 and 1 watched, all high; pins 2 and 3 masked
    i_pb.hold_pins(8'h01, 1'b1);
    @(negedge clk);
    chk({7'h00, irq_oe}, 8'h00);
    i_pb.hold_pins(8'h03, 1'b1);
    @(negedge clk);
    chk({7'h00, irq_oe}, 8'h01);
    m1_n = 1'b0;
    io_request_n_n = 1'b0;
    @(negedge clk);
    chk(d_out, 8'h40);
    m1_n = 1'b1;
    io_request_n_n = 1'b1;
    fetch(RETURN_FROM_IRQ_OPCODE_PREFIX);
    fetch(RETURN_FROM_IRQ_OPCODE_CODE);
    @(negedge clk);
    chk({6'h00, irq_oe, chain_out}, 8'h01);
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'h03);
    i_pb.hold_pins(8'h00, 1'b1);
    i_pb.hold_pins(8'h03, 1'b1);
    @(negedge clk);
    chk({7'h00, irq_oe}, 8'h00);
    bus(1'b0, 1'b1, 1'b1, 1'b0, 8'h83);
    i_pb.hold_pins(8'h00, 1'b1);
    i_pb.hold_pins(8'h03, 1'b1);
    @(negedge clk);
    chk({7'h00, irq_oe}, 8'h01);
    i_pb.hold_pins(8'h00, 1'b0);
    $display("done: bit mode interrupt");
  endtask

  task automatic t_busreset;
    @(negedge clk);
    m1_n = 1'b0;
    repeat (2) @(negedge clk);
    m1_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(pa_oe | pb_oe, 8'h00);
    chk(pa_out | pb_out, 8'h00);
    chk({6'h00, pa_rdy, pb_rdy}, 8'h00);
    $display("done: bus reset");
  endtask

  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      give_verdict;
    end
  end

  initial begin
    n_errors = 0;
    checked = 0;
    cycles = 0;
    rst_n = 1'b0;
    {cs_n, io_request_n_n, rd_n, m1_n} = 4'hf;
    {cds, ps, bus_oe} = 3'h0;
    chain_in = 1'b1;
    dbus = 8'h00;
    rdat = 8'h00;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset;
    t_output;
    t_irq;
    t_fifo;
    t_bit;
    t_busreset;
    t_bitirq;
    give_verdict;
  end
endmodule
